//--- shm_multiply.sv
// Behaviour
// - first halfword select picks first source half
// - second halfword select picks second source half
// - word form halfword select picks second half
// - half form gives full signed 32-bit product
// - word form keeps upper 32 of 48
// - commit result only when condition holds
`include "shm_regs.svh"
module shm_multiply
  import shm_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  // request from decoder and register file
  input  wire logic        VALID_I,
  input  wire logic        FORM_I,
  input  wire logic        FIRST_SEL_I,
  input  wire logic        SECOND_SEL_I,
  input  wire logic        COND_PASS_I,
  input  wire logic [3:0]  DEST_I,
  input  wire logic [31:0] FIRST_SRC_REG_I,
  input  wire logic [31:0] SECOND_SRC_REG_I,
  // write port towards the register file
  output logic             WR_EN_O,
  output logic      [3:0]  WR_ADDR_O,
  output logic      [31:0] WR_DATA_O
);

  // whole state of the unit
  typedef struct packed {
    logic        s1_valid;   // stage 1 holds a request
    logic        s1_form;    // form of the stage 1 request
    logic        s1_commit;  // condition passed in stage 1
    logic [3:0]  s1_dest;    // destination of stage 1
    logic        wr_en;      // result write strobe
    logic [3:0]  wr_addr;    // result destination
    logic [31:0] wr_data;    // result word
  } shm_state_t;

  shm_state_t st;       // registered state
  shm_state_t next_st;  // next state

  logic [31:0] mul_a;    // sign-extended first operand
  logic [31:0] mul_b;    // sign-extended second operand
  logic [63:0] product;  // registered product, stage 1

  // all checks below run on the core clock and rest during reset
  default clocking cb_core @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  // pick a signed halfword and extend it to a word
  function automatic logic [31:0] shm_pick_half(
    input logic [31:0] word,
    input logic        top
  );
    logic [15:0] h;
    h = top ? word[`SHM_TOP_LSB +: `SHM_HALF_W]
            : word[`SHM_BOT_LSB +: `SHM_HALF_W];
    return {{16{h[15]}}, h};
  endfunction

  // operand selection; the sources are captured in the multiplier
  // flop on the request edge, so a destination equal to a source
  // cannot disturb the product
  // in the word form the first select is ignored: the whole first word
  // is the multiplicand; both operands are sign-extended to 32 bits so
  // that one signed core serves both forms without a mode input
  always_comb begin
    if (FORM_I == SHM_WORD_BY_HALF) begin
      mul_a = FIRST_SRC_REG_I;
      mul_b = shm_pick_half(SECOND_SRC_REG_I, SECOND_SEL_I);
    end else begin
      mul_a = shm_pick_half(FIRST_SRC_REG_I, FIRST_SEL_I);
      mul_b = shm_pick_half(SECOND_SRC_REG_I, SECOND_SEL_I);
    end
  end

  // multiplier stage, shared by both forms
  // its output flop is stage 1 of the product; the control fields ride
  // alongside in st.s1_* so that both arrive at stage 2 together
  shm_mul_core u_mul (
    .CLK_I    (CLK_I),
    .ARST_N_I (ARST_N_I),
    .a_i      (mul_a),
    .b_i      (mul_b),
    .p_o      (product)
  );

  // pipeline control and result shaping
  // stage 1 copies the request fields on every edge; an idle cycle just
  // carries a cleared valid bit forward, so no bubble logic is needed
  always_comb begin
    next_st           = st;
    next_st.s1_valid  = VALID_I;
    next_st.s1_form   = FORM_I;
    next_st.s1_commit = VALID_I & COND_PASS_I;
    next_st.s1_dest   = DEST_I;
    // a failed condition leaves the destination untouched
    next_st.wr_en     = st.s1_valid & st.s1_commit;
    // address and data follow each valid request, passing or not, so
    // the port shows a skipped result too and holds only through idle cycles
    if (st.s1_valid) begin
      next_st.wr_addr = st.s1_dest;
      if (st.s1_form == SHM_WORD_BY_HALF) begin
        // bits 47..16 of the 48-bit product
        next_st.wr_data = product[`SHM_WIDE_W-1:`SHM_HALF_W];
      end else begin
        next_st.wr_data = product[`SHM_WORD_W-1:0];
      end
    end
  end

  // state register
  // the async clear drops the strobe at once: a request caught in
  // flight by reset is lost, never written late
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st <= '{default: '0, wr_data: `SHM_RESULT_RST};
    end else begin
      st <= next_st;
    end
  end

  assign WR_EN_O   = st.wr_en;
  assign WR_ADDR_O = st.wr_addr;
  assign WR_DATA_O = st.wr_data;

  // checks: each property samples a request at its taking edge and
  // looks at the write port two edges later, once stage 2 holds it;
  // $past(..., 2) recovers the operands as they stood when taken
  // result data follow every valid request, so the data checks leave
  // the condition out and so cover skipped writes as well

  // bottom by bottom: full signed 32-bit product of the low halves
  // a wrong sign extension shows up on the negative corner operands
  a_half_bot_bot: assert property (
    (VALID_I && FORM_I == SHM_HALF_BY_HALF
     && !FIRST_SEL_I && !SECOND_SEL_I)
    |-> ##2 (WR_DATA_O == 32'($signed($past(FIRST_SRC_REG_I[15:0], 2))
             * $signed($past(SECOND_SRC_REG_I[15:0], 2)))))
    else $error("bottom by bottom product wrong");

  // first select top: the upper half of the first source is used
  // the second select stays bottom so only the first mux is tested
  a_half_top_sel: assert property (
    (VALID_I && FORM_I == SHM_HALF_BY_HALF
     && FIRST_SEL_I && !SECOND_SEL_I)
    |-> ##2 (WR_DATA_O == 32'($signed($past(FIRST_SRC_REG_I[31:16], 2))
             * $signed($past(SECOND_SRC_REG_I[15:0], 2)))))
    else $error("first top select wrong");

  // second select top: the upper half of the second source is used
  // the first select stays bottom so only the second mux is tested
  a_half_top_snd: assert property (
    (VALID_I && FORM_I == SHM_HALF_BY_HALF
     && !FIRST_SEL_I && SECOND_SEL_I)
    |-> ##2 (WR_DATA_O == 32'($signed($past(FIRST_SRC_REG_I[15:0], 2))
             * $signed($past(SECOND_SRC_REG_I[31:16], 2)))))
    else $error("second top select wrong");

  // both selects top: the two upper halves multiplied together
  // closes the fourth pairing of the half by half form
  a_half_top_top: assert property (
    (VALID_I && FORM_I == SHM_HALF_BY_HALF
     && FIRST_SEL_I && SECOND_SEL_I)
    |-> ##2 (WR_DATA_O == 32'($signed($past(FIRST_SRC_REG_I[31:16], 2))
             * $signed($past(SECOND_SRC_REG_I[31:16], 2)))))
    else $error("top by top product wrong");

  // word by top half: bits 47..16 of the signed 48-bit product
  // the arithmetic shift keeps the sign of a negative product
  a_word_top_res: assert property (
    (VALID_I && FORM_I == SHM_WORD_BY_HALF && SECOND_SEL_I)
    |-> ##2 (WR_DATA_O == 32'(64'($signed($past(FIRST_SRC_REG_I, 2))
             * $signed($past(SECOND_SRC_REG_I[31:16], 2))) >>> 16)))
    else $error("word by top half result wrong");

  // word by bottom half: upper 32 bits of the 48-bit product
  // the first select is left free, since this form must ignore it
  a_word_bot_res: assert property (
    (VALID_I && FORM_I == SHM_WORD_BY_HALF && !SECOND_SEL_I)
    |-> ##2 (WR_DATA_O == 32'(64'($signed($past(FIRST_SRC_REG_I, 2))
             * $signed($past(SECOND_SRC_REG_I[15:0], 2))) >>> 16)))
    else $error("word by bottom half result wrong");

  // a passing request is written to its own destination
  a_cond_commit: assert property (
    (VALID_I && COND_PASS_I)
    |-> ##2 (WR_EN_O && WR_ADDR_O == $past(DEST_I, 2)))
    else $error("passing request not written");

  // every write strobe goes back to a passing request
  a_cond_block: assert property (
    WR_EN_O |-> $past(VALID_I && COND_PASS_I, 2))
    else $error("write without passing request");

  // a failed condition leaves the destination untouched
  a_fail_no_write: assert property (
    (VALID_I && !COND_PASS_I) |-> ##2 !WR_EN_O)
    else $error("failed condition still written");

  // an idle cycle never produces a write
  a_idle_no_write: assert property (
    !VALID_I |-> ##2 !WR_EN_O)
    else $error("write without any request");

  // the address follows every valid request, passing or not
  a_dest_follow: assert property (
    VALID_I |-> ##2 (WR_ADDR_O == $past(DEST_I, 2)))
    else $error("destination not carried to port");

  // an idle cycle leaves address and data where they stood
  a_idle_hold: assert property (
    !VALID_I |-> ##2 ($stable(WR_DATA_O) && $stable(WR_ADDR_O)))
    else $error("result port moved without a request");

  // a source that changes after the taking edge, as when the previous
  // result lands in it, must not reach the product
  a_src_capture: assert property (
    (VALID_I && FORM_I == SHM_WORD_BY_HALF && !SECOND_SEL_I)
    ##1 $changed(FIRST_SRC_REG_I)
    |-> ##1 (WR_DATA_O == 32'(64'($signed($past(FIRST_SRC_REG_I, 2))
             * $signed($past(SECOND_SRC_REG_I[15:0], 2))) >>> 16)))
    else $error("result follows later source value");
endmodule

//--- shm_regs.svh
`ifndef SHM_REGS_SVH
`define SHM_REGS_SVH
// operand and result widths
`define SHM_WORD_W      32
`define SHM_HALF_W      16
`define SHM_WIDE_W      48
// halfword field positions inside a source word
`define SHM_BOT_LSB     0
`define SHM_TOP_LSB     16
// reset value of the result register
`define SHM_RESULT_RST  32'h00000000
// cycles from an accepted request to its answer
`define SHM_LATENCY     2
`endif

//--- shm_pkg.sv
package shm_pkg;
  // which of the two instruction forms is requested
  typedef enum logic {
    SHM_HALF_BY_HALF,
    SHM_WORD_BY_HALF
  } shm_form_t;
  // halfword select: bottom or top half of a source word
  typedef enum logic {
    SHM_SEL_BOTTOM,
    SHM_SEL_TOP
  } shm_half_sel_t;
endpackage

//--- shm_mul_core.sv
`include "shm_regs.svh"
// registered signed 32 x 32 multiplier; one cycle latency
module shm_mul_core (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  // operands
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  // registered product
  output logic      [63:0] p_o
);
  // a single flop after the multiplier keeps the product path short
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      p_o <= 64'h0000000000000000;
    end else begin
      p_o <= 64'($signed(a_i) * $signed(b_i));
    end
  end
endmodule

//--- shm_rf_model.sv
// register file beside the multiplier: feeds sources, takes results
module shm_rf_model (
  // clock
  input  wire logic        clk_i,
  // write port from the multiplier
  input  wire logic        we_i,
  input  wire logic [3:0]  wa_i,
  input  wire logic [31:0] wd_i,
  // read ports towards the multiplier
  input  wire logic [3:0]  ra_i,
  input  wire logic [3:0]  rb_i,
  output logic      [31:0] a_o,
  output logic      [31:0] b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rf [16]; // sixteen general registers
  // spread start values so that early products are not all zero
  initial begin
    for (int k = 0; k < 16; k++) begin
      rf[k] = 32'h9E3779B9 * (k + 1);
    end
  end
  // a result lands only on the strobe; a failed condition leaves it intact
  always @(posedge clk_i) begin
    if (we_i) begin
      rf[wa_i] <= wd_i;
    end
  end
  assign a_o = rf[ra_i];
  assign b_o = rf[rb_i];
endmodule

//--- tb_signed_halfword_multiply.sv
module tb_signed_halfword_multiply;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, vld, frm, s1, s2, cnd, we;
  logic [3:0]  dst, ra, rb, wa;
  logic [31:0] a, b, wd, r;
  logic [37:0] q0, q1; // expected {valid, cond, dest, data}, two deep
  logic [35:0] last;   // expected {dest, data} standing on the port
  integer      n_fail, comparisons, cyc, seed, i;
  always #5 clk = ~clk;
  shm_multiply uut (.CLK_I(clk), .ARST_N_I(rst_n), .VALID_I(vld),
    .FORM_I(frm), .FIRST_SEL_I(s1), .SECOND_SEL_I(s2), .COND_PASS_I(cnd),
    .DEST_I(dst), .FIRST_SRC_REG_I(a), .SECOND_SRC_REG_I(b),
    .WR_EN_O(we), .WR_ADDR_O(wa), .WR_DATA_O(wd));
  shm_rf_model p (.clk_i(clk), .we_i(we), .wa_i(wa), .wd_i(wd),
    .ra_i(ra), .rb_i(rb), .a_o(a), .b_o(b));
  // reference product worked out from the operand rules
  function automatic logic [31:0] expv(input logic f, x, y,
                                       input logic [31:0] m, n);
    logic signed [15:0] h1;
    logic signed [15:0] h2;
    logic signed [31:0] ph;
    logic signed [47:0] pw;
    h1 = x ? m[31:16] : m[15:0];
    h2 = y ? n[31:16] : n[15:0];
    ph = h1 * h2;
    pw = $signed(m) * h2;
    return f ? pw[47:16] : ph;
  endfunction
  task chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one cycle: check the answer due now, then offer the next request
  task step(input logic v, f, x, y, c, input logic [3:0] d, m, n);
    @(posedge clk);
    #1;
    chk("WR_EN_O", 32'(we), 32'(q1[37] & q1[36]));
    if (q1[37]) last = q1[35:0];
    chk("WR_ADDR_O", 32'(wa), 32'(last[35:32]));
    chk("WR_DATA_O", wd, last[31:0]);
    {vld, frm, s1, s2, cnd, dst, ra, rb} = {v, f, x, y, c, d, m, n};
    #1;
    q1 = q0;
    q0 = {v, c, d, expv(f, x, y, a, b)};
  endtask
  // hang guard, well above the ~535 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    {clk, vld, frm, s1, s2, cnd, dst, ra, rb} = '0;
    {rst_n, n_fail, comparisons, cyc, q0, q1, last} = '0;
    seed = 32'hD2E47E8D;
    #1;
    p.rf[1] = 32'h80007FFF; // extreme halves for sign corners
    p.rf[2] = 32'h80008000;
    repeat (12) @(posedge clk);
    chk("WR_EN_O", 32'(we), 32'h0);
    #1 rst_n = 1;
    // every form and select pairing on the extreme operands
    for (i = 0; i < 8; i++) begin
      step(1, i[2], i[1], i[0], 1, 4'h3, 4'h1, 4'h2);
    end
    // random back-to-back traffic; dest often equals a source
    for (i = 0; i < 500; i++) begin
      r = $random(seed);
      step(r[0] | r[1], r[2], r[3], r[4], r[5] | r[6], r[10:7], r[14:11],
           r[18:15]);
    end
    repeat (2) step(0, 0, 0, 0, 0, 4'h0, 4'h0, 4'h0);
    // reset in mid-run: port clears, then chained dest-equals-source work
    #1 rst_n = 0;
    {q0, q1, last} = '0;
    repeat (3) @(posedge clk);
    #1;
    chk("WR_EN_O", 32'(we), 32'h0);
    chk("WR_DATA_O", wd, 32'h0);
    rst_n = 1;
    for (i = 0; i < 8; i++) begin
      step(1, i[2], i[0], i[1], 1, 4'h1, 4'h1, 4'h2);
    end
    repeat (2) step(0, 0, 0, 0, 0, 4'h0, 4'h0, 4'h0);
    results;
  end
endmodule
